// *** verilog/hpe_defines.vh ***
/*
  constants for the fine-resolution pwm edge block: timing counts, field widths, reset values.
  assumes a 25 MHz system clock and inclusion by bare name from the design file.
*/
`ifndef HPE_DEFINES_VH
`define HPE_DEFINES_VH
`define HPE_CLK_MHZ           25
`define HPE_FINE_STEP_TYP_PS  150
`define HPE_FINE_STEP_MAX_PS  310
`define HPE_SYNC_OUT_MIN_CYC  8'h08
`define HPE_CNT_W             16
`define HPE_EXT_W             8
`define HPE_TAP_W             8
`define HPE_TRIP_HIGH         2'h0
`define HPE_TRIP_LOW          2'h1
`define HPE_TRIP_HIZ          2'h2
`define HPE_TRIP_NONE         2'h3
`define HPE_PRD_RST           16'h00FF
`endif

// *** verilog/hpe_edge_trip.v ***
/*
  pulse modulator unit with a fine_resolution_extension on its first output, sync in/out
  and trip forcing. assumes outside pins are asynchronous (two-flop synchronised here) and that
  the fine delay taps drive an analogue delay line cell outside this logic.
*/
// What this block does
// [RULE1] each modulator unit has one fine delay line, plus one calibration delay line
// [RULE2] fine placement only on the first output; second output stays clock-granular
// [RULE3] fine position comes from compare-a and phase extension fields
// [RULE4] fine resolution serves single-edge duty/phase and dual-edge period modulation
// [RULE5] in fine period mode the second output may jitter one to two time-base clocks
// [RULE6] system clock must be at least the stated minimum when fine mode is used
// [RULE7] fine step nominally 150 ps, at most 310 ps, counted within one clock period
// [RULE8] each sync output pulse stays high at least eight system clocks
// [RULE9] sync input pulses held at least two system clocks by the source
// [RULE10] trip input held low at least two time-base clocks by the source
// [RULE11] an active trip forces outputs high, low or hi-z at once
// [RULE12] outputs stay forced after trip release until software rearms
// [RULE13] compare-a and phase fine extensions are separate software-set values
// [RULE14] fine delay equals extension times step, added after the coarse edge
`include "hpe_defines.vh"

module hpe_edge_trip #(
  parameter CNT_W  = `HPE_CNT_W,
  parameter EXT_W  = `HPE_EXT_W,
  parameter TRIP_N = 6
) (
  input  wire              clk,
  input  wire              nrst,
  input  wire              tb_clk_en,
  input  wire [CNT_W-1:0]  period,
  input  wire [CNT_W-1:0]  compare_a,
  input  wire [EXT_W-1:0]  compare_a_fine_extension,  // RULE13
  input  wire [CNT_W-1:0]  compare_b,
  input  wire [CNT_W-1:0]  phase,
  input  wire [EXT_W-1:0]  phase_fine_extension,      // RULE13
  input  wire              fine_enable,
  input  wire              fine_period_mode,
  input  wire              phase_load_en,
  input  wire [1:0]        trip_action,
  input  wire [TRIP_N-1:0] trip_input_n,
  input  wire              trip_rearm,
  input  wire              sync_in,
  input  wire [EXT_W-1:0]  cal_tap_code,
  output reg               modulator_output_first,
  output reg               modulator_output_first_oe,
  output reg  [EXT_W-1:0]  first_fine_tap,
  output reg               modulator_output_second,
  output reg               modulator_output_second_oe,
  output reg               sync_out,
  output reg  [EXT_W-1:0]  cal_fine_tap,
  output reg               tripped
);

  localparam [7:0] SYNC_HOLD = `HPE_SYNC_OUT_MIN_CYC;
  localparam [1:0] TR_HIGH = `HPE_TRIP_HIGH;
  localparam [1:0] TR_LOW  = `HPE_TRIP_LOW;
  localparam [1:0] TR_HIZ  = `HPE_TRIP_HIZ;

  // saturating one-step increment used by sync hold counter
  function [7:0] sat_inc;
    input [7:0] v;
    begin
      sat_inc = (v == 8'hFF) ? v : v + 8'h01;
    end
  endfunction

  // fine tap sum wraps at the field width; the carry is dropped on purpose
  function [EXT_W-1:0] fine_sum;
    input [EXT_W-1:0] a;
    input [EXT_W-1:0] b;
    reg   [EXT_W:0]   full;
    begin
      full     = {1'b0, a} + {1'b0, b};
      fine_sum = full[EXT_W-1:0];
    end
  endfunction

  // two-flop synchronisers for pins
  reg [TRIP_N-1:0] trip_s1, trip_s2;
  reg              sync_s1, sync_s2, sync_s3;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trip_s1 <= {TRIP_N{1'b1}};
      trip_s2 <= {TRIP_N{1'b1}};
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
    end else begin
      trip_s1 <= trip_input_n;
      trip_s2 <= trip_s1;
      sync_s1 <= sync_in;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
    end
  end

  wire trip_any  = ~&trip_s2;
  wire sync_rise = sync_s2 & ~sync_s3;            // RULE9

  // time base counter; sync rise loads phase
  reg [CNT_W-1:0] tb_cnt;
  wire            tb_wrap = tb_clk_en && (tb_cnt >= period);
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      tb_cnt <= {CNT_W{1'b0}};
    else if (sync_rise && phase_load_en)
      tb_cnt <= phase;                            // RULE3
    else if (tb_wrap)
      tb_cnt <= {CNT_W{1'b0}};
    else if (tb_clk_en)
      tb_cnt <= tb_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  // fine tap: compare extension, in period mode also phase extension
  reg [EXT_W-1:0] next_tap;
  always @* begin
    next_tap = {EXT_W{1'b0}};
    if (fine_enable) begin
      if (fine_period_mode)
        next_tap = fine_sum(compare_a_fine_extension, phase_fine_extension); // RULE4
      else
        next_tap = compare_a_fine_extension;    // RULE3
    end
  end

  // coarse compare levels; only the first path gets a fine tap afterwards
  wire coarse_a  = (tb_cnt < compare_a);
  wire coarse_b  = (tb_cnt < compare_b);          // RULE2
  wire force_now = trip_any | tripped;            // forcing starts on the trip edge itself

  // trip latch: a live trip wins over a rearm in the same cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      tripped <= 1'b0;
    else if (trip_any)
      tripped <= 1'b1;                            // RULE11
    else if (trip_rearm)
      tripped <= 1'b0;                            // RULE12
  end

  // calibration delay line: its own tap, never forced by a trip
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      cal_fine_tap <= {EXT_W{1'b0}};
    else
      cal_fine_tap <= cal_tap_code;               // RULE1
  end

  // first path: coarse edge plus fine tap, or the forced trip state
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      modulator_output_first    <= 1'b0;
      modulator_output_first_oe <= 1'b1;
      first_fine_tap            <= {EXT_W{1'b0}};
    end else if (force_now) begin
      first_fine_tap <= {EXT_W{1'b0}};            // no fine delay on a forced pin
      case (trip_action)
        TR_HIGH: begin
          modulator_output_first    <= 1'b1;      // RULE11
          modulator_output_first_oe <= 1'b1;
        end
        TR_LOW: begin
          modulator_output_first    <= 1'b0;      // RULE11
          modulator_output_first_oe <= 1'b1;
        end
        TR_HIZ: begin
          modulator_output_first_oe <= 1'b0;      // RULE11
        end
        default: begin
          modulator_output_first_oe <= 1'b1;      // keep driving the last level
        end
      endcase
    end else begin
      modulator_output_first    <= coarse_a;      // RULE14
      modulator_output_first_oe <= 1'b1;
      first_fine_tap            <= next_tap;      // RULE7
    end
  end

  // extra stage that models the period-mode edge jitter of the second path
  reg second_delay;
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      second_delay <= 1'b0;
    else
      second_delay <= coarse_b;
  end

  // second path: clock-granular only, or the forced trip state
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      modulator_output_second    <= 1'b0;
      modulator_output_second_oe <= 1'b1;
    end else if (force_now) begin
      case (trip_action)
        TR_HIGH: begin
          modulator_output_second    <= 1'b1;     // RULE11
          modulator_output_second_oe <= 1'b1;
        end
        TR_LOW: begin
          modulator_output_second    <= 1'b0;     // RULE11
          modulator_output_second_oe <= 1'b1;
        end
        TR_HIZ: begin
          modulator_output_second_oe <= 1'b0;     // RULE11
        end
        default: begin
          modulator_output_second_oe <= 1'b1;     // keep driving the last level
        end
      endcase
    end else begin
      modulator_output_second    <= fine_period_mode ? second_delay : coarse_b; // RULE5
      modulator_output_second_oe <= 1'b1;
    end
  end

  // sync out on counter wrap, stretched to the minimum width
  reg [7:0] sync_cnt;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_out <= 1'b0;
      sync_cnt <= 8'h00;
    end else if (tb_wrap) begin
      sync_out <= 1'b1;                           // RULE8
      sync_cnt <= 8'h01;
    end else if (sync_out) begin
      sync_cnt <= sat_inc(sync_cnt);
      if (sync_cnt >= SYNC_HOLD)
        sync_out <= 1'b0;                         // RULE8
    end
  end
endmodule // hpe_edge_trip

// *** tb/hpe_far_side.sv ***
/* far side model: trip and sync pin sources.
   assumes bench requests; pins change just after the rising clock. */
module hpe_far_side (
  input  wire logic       clk, trip_req, sync_req,
  input  wire logic [2:0] trip_sel,
  output logic      [5:0] trip_input_n = 6'h3F,
  output logic            sync_in = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic t1 = 1'b0;
  logic s1 = 1'b0;
  // stretch each request one clock so no pulse is shorter than two cycles
  always @(posedge clk) begin
    t1 <= trip_req;
    s1 <= sync_req;
    trip_input_n <= (trip_req | t1) ? ~(6'h01 << trip_sel) : 6'h3F;
    sync_in <= sync_req | s1;
  end
endmodule // hpe_far_side

// *** tb/hpe_edge_trip_sva.sv ***
/* port checker for hpe_edge_trip: trip forcing, sync width, fine taps.
   assumes one clock domain and the bind at the foot of this file. */
module hpe_edge_trip_chk #(parameter EXT_W = 8, parameter TRIP_N = 6) (
  input wire              clk, nrst, fine_enable, fine_period_mode, trip_rearm, tripped,
  input wire              sync_out, modulator_output_first, modulator_output_first_oe,
  input wire              modulator_output_second, modulator_output_second_oe,
  input wire [1:0]        trip_action,
  input wire [TRIP_N-1:0] trip_input_n,
  input wire [EXT_W-1:0]  compare_a_fine_extension, phase_fine_extension,
  input wire [EXT_W-1:0]  cal_tap_code, cal_fine_tap, first_fine_tap
);
  wire [EXT_W-1:0] tap_sum = compare_a_fine_extension + phase_fine_extension;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_trip_held;
    !(&trip_input_n) [*2];
  endsequence
  // forced pin state once the trip has settled for a cycle
  property p_forced(code, lvl, en);
    tripped && $past(tripped) && $stable(trip_action) && trip_action == code |->
      modulator_output_first_oe == en && modulator_output_second_oe == en &&
      (!en || (modulator_output_first == lvl && modulator_output_second == lvl));
  endproperty
  chk_trip_latch: assert property (s_trip_held |-> ##[1:3] tripped)
    else $error("trip not latched");
  chk_force_high: assert property (p_forced(2'b00, 1'b1, 1'b1))
    else $error("outputs not forced high");
  chk_force_low: assert property (p_forced(2'b01, 1'b0, 1'b1))
    else $error("outputs not forced low");
  chk_force_hiz: assert property (p_forced(2'b10, 1'b0, 1'b0))
    else $error("outputs not released to hi-z");
  chk_trip_hold: assert property (tripped && !trip_rearm |=> tripped)
    else $error("trip cleared without rearm");
  chk_sync_width: assert property ($rose(sync_out) |=> sync_out [*7])
    else $error("sync out pulse too short");
  chk_cal_tap: assert property ($past(nrst) |-> cal_fine_tap == $past(cal_tap_code))
    else $error("calibration tap not following code");
  chk_tap_off: assert property (!fine_enable [*2] |-> first_fine_tap == 0)
    else $error("fine tap active while disabled");
  chk_tap_sum: assert property (fine_enable && fine_period_mode && !tripped &&
    $past(fine_enable && fine_period_mode && !tripped) && $stable(tap_sum)
    |-> first_fine_tap == tap_sum)
    else $error("fine tap not sum of extensions");
endmodule // hpe_edge_trip_chk
bind hpe_edge_trip hpe_edge_trip_chk #(.EXT_W(EXT_W), .TRIP_N(TRIP_N)) chk (.*);

// *** tb/hpe_edge_trip_tb_top.sv ***
/* bench for hpe_edge_trip: calibration tap, fine taps, sync out, trip.
   assumes hpe_far_side drives the trip and sync pins. */
module hpe_edge_trip_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, nrst = 0, tb_clk_en = 1, fine_enable = 0, fine_period_mode = 0;
  logic phase_load_en = 1, trip_rearm = 0, trip_req = 0, sync_req = 0;
  logic [15:0] period = 16'h0010, compare_a = 16'h0008, compare_b = 16'h0004;
  logic [15:0] phase = 16'h0002;
  logic [7:0] compare_a_fine_extension = 0, phase_fine_extension = 0, cal_tap_code = 0;
  logic [7:0] first_fine_tap, cal_fine_tap;
  logic [1:0] trip_action = 0;
  logic [2:0] trip_sel = 0;
  logic [5:0] trip_input_n;
  logic sync_in, modulator_output_first, modulator_output_first_oe, sync_out, tripped;
  logic modulator_output_second, modulator_output_second_oe;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  hpe_edge_trip uut (.*);
  hpe_far_side far (.*);
  // bench clock at the 25 MHz the defines assume; fine taps are modelled as codes, not as real delay cells
  always #20 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run;
    end
  end
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task sc_cal;
    for (int i = 0; i < 3; i++) begin
      cal_tap_code = 8'h55 * i;
      cyc(2);
      chk("cal_tap", cal_fine_tap, 8'h55 * i);
    end
  endtask
  task sc_fine;
    fine_enable = 1;
    fine_period_mode = 1;
    compare_a_fine_extension = 8'hF0;
    phase_fine_extension = 8'h25;
    sync_req = 1;
    cyc(1);
    sync_req = 0;
    cyc(3);
    chk("fine_sum", first_fine_tap, 8'h15);
    fine_period_mode = 0;
    cyc(2);
    chk("fine_single", first_fine_tap, 8'hF0);
    fine_enable = 0;
    cyc(3);
    chk("fine_off", first_fine_tap, 8'h00);
  endtask
  task sc_sync;
    int n;
    n = 0;
    for (int k = 0; k < 40 && sync_out !== 1'b0; k++) cyc(1);
    for (int k = 0; k < 40 && sync_out !== 1'b1; k++) cyc(1);
    while (sync_out === 1'b1 && n < 40) begin
      n++;
      cyc(1);
    end
    chk("sync_width", n >= 8, 8'h01);
  endtask
  // duty of both paths over one period, time base every cycle or every other cycle
  task automatic sc_pwm(input logic slow, input logic jitter);
    int hi_a, hi_b, len;
    hi_a = 0;
    hi_b = 0;
    len = slow ? 34 : 17;
    fine_period_mode = jitter;
    for (int k = 0; k < 2 * len; k++) begin
      tb_clk_en = slow ? k[0] : 1'b1;
      cyc(1);
      if (k >= len) begin
        hi_a += (modulator_output_first === 1'b1);
        hi_b += (modulator_output_second === 1'b1);
      end
    end
    tb_clk_en = 1;
    fine_period_mode = 0;
    chk("duty_first", 8'(hi_a), slow ? 8'h10 : 8'h08);
    chk("duty_second", 8'(hi_b), slow ? 8'h08 : 8'h04);
  endtask
  // trip latched, then a reset in mid-run clears it and leaves the pins driven
  task sc_reset;
    trip_action = 2'h0;
    trip_sel = 3'h1;
    trip_req = 1;
    cyc(1);
    trip_req = 0;
    cyc(8);
    chk("trip_before_reset", tripped, 8'h01);
    nrst = 0;
    cyc(2);
    chk("reset_trip", tripped, 8'h00);
    chk("reset_oe", {modulator_output_first_oe, modulator_output_second_oe}, 8'h03);
    nrst = 1;
    cyc(2);
    chk("after_reset", {tripped, modulator_output_first_oe, sync_out}, 8'h02);
  endtask
  task sc_trip;
    // code 3 keeps the pins driven at their last level
    for (int a = 0; a < 4; a++) begin
      trip_action = a;
      trip_sel = 3'(a == 3 ? 5 : a * 2);
      trip_req = 1;
      cyc(2);
      trip_req = 0;
      cyc(3);
      chk("tripped", tripped, 8'h01);
      chk("forced", {modulator_output_first_oe, modulator_output_second_oe,
        (a < 2) & modulator_output_first, (a < 2) & modulator_output_second},
        {a != 2, a != 2, a == 0, a == 0});
      cyc(4);
      chk("held", tripped, 8'h01);
      trip_rearm = 1;
      cyc(1);
      trip_rearm = 0;
      cyc(2);
      chk("rearmed", tripped, 8'h00);
    end
  endtask
  initial begin
    cyc(8);
    nrst = 1;
    cyc(2);
    sc_cal;
    sc_fine;
    sc_pwm(1'b0, 1'b0);
    sc_pwm(1'b1, 1'b1);
    sc_sync;
    sc_trip;
    sc_reset;
    complete_run;
  end
endmodule // hpe_edge_trip_tb_top
